// ==== flash_host_pkg.sv ====
// constants, types and carriers for the parallel flash command host
// assumes a byte-wide flash with 19 address bits and a 20 MHz host clock
package flash_host_pkg;

   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int SECTOR_LSB = 16;
   localparam int SECTOR_W = 3;
   localparam int FAIL_BIT = 5;

   // clock and strobe timing, in ns, and the derived cycle counts
   localparam int CLK_NS = 50;
   localparam int WRITE_PULSE_NS = 100;
   localparam int WRITE_HIGH_NS = 50;
   localparam int READ_ACCESS_NS = 150;
   localparam int WR_LOW_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_ACC_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_CYC = 2;

   // command cycles
   localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
   localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
   localparam logic [7:0] UNLOCK1_DATA = 8'haa;
   localparam logic [7:0] UNLOCK2_DATA = 8'h55;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_RESET = 8'hf0;

   // identification read addresses (low bits)
   localparam logic [15:0] ID_MAKER_LOW = 16'h0000;
   localparam logic [15:0] ID_PART_LOW = 16'h0001;
   localparam logic [15:0] ID_PROT_LOW = 16'h0002;

   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_PROGRAM, OP_IDENT, OP_PROTECT, OP_RESET,
      OP_STATUS
   } op_type;

   typedef struct packed {
      op_type op;
      logic [18:0] addr;
      logic [7:0] data;
   } request_type;

   typedef struct packed {
      logic [7:0] data;
      logic failSeen;
   } response_type;

   typedef struct packed {
      logic [18:0] addr;
      logic [7:0] data;
      logic last;
   } step_type;

endpackage : flash_host_pkg

// ==== flash_cmd_host.sv ====
// host controller driving a byte-wide parallel flash through its strobes
// assumes one request at a time from logic on clk; flash data comes from
// a pin and is synchronised before use
// Function
// R1: device floats data while output-enable high; the model drives the inverse of the last byte instead
// R2: top three address bits pick sector
// R3: host writes two unlocks then identification command
// R4: identification reads repeat without new command
// R5: low address zero maker, one part
// R6: address two with sector gives protection
// R7: host leaves identification only by reset
// R8: wrong or misordered cycle returns array read
// R9: address taken on later falling strobe
// R10: data taken on first rising strobe
// R11: write only with ce, we low, oe high
// R12: power-up held strobes give no command
// R13: power-up lands in array read
// R14: supply lockout rejects writes and resets
// R15: finished algorithm returns to array read
// R16: suspended sectors read status, others data
// R17: host writes reset when fail flag rises
// R18: reset command recognised by data alone
// R19: reset aborts unfinished sequences, not running ones
// R20: reset cancels partial identification sequence
// R21: protected sectors refuse program and erase
// R22: all sectors start unprotected; the bench starts the model with sector 5 protected (PROT 8'h20)
// R23: host reads with ce, oe low, we high
// R24: identification exit returns to erase suspend
// R25: one write pulse counts one command cycle
`timescale 1ns/1ns
module flash_cmd_host
   import flash_host_pkg::*;
#(
   parameter int WR_LOW = WR_LOW_CYC,
   parameter int WR_HIGH = WR_HIGH_CYC,
   parameter int ACCESS = READ_ACC_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // request and answer
   input wire logic reqValid,
   output logic reqReady,
   input wire request_type req,
   output logic rspValid,
   output response_type rsp,
   output logic identMode,
   // flash pins
   output logic [18:0] flashAddr,
   output logic ceN,
   output logic oeN,
   output logic weN,
   output logic [7:0] dqOut,
   output logic dqOe,
   input wire logic [7:0] dqIn
);

   if (WR_LOW < 1 || WR_LOW > 15 || WR_HIGH < 1 || WR_HIGH > 15 ||
       ACCESS < 1 || ACCESS + SYNC_CYC > 15) begin : g_check
      $error("flash_cmd_host: strobe counts out of range");
   end

   typedef enum logic [2:0] {
      S_IDLE, S_SETUP, S_WLOW, S_WHIGH, S_RLOW, S_RESP
   } state_type;

   state_type state_r;
   request_type req_r;
   logic [2:0] idx_r;
   logic [3:0] cnt_r;
   logic [18:0] addr_r;
   logic ceN_r, oeN_r, weN_r, dqOe_r;
   logic [7:0] dqOut_r, dqSync1_r, dqSync2_r;
   logic rspValid_r, identMode_r;
   response_type rsp_r;

   // command cycle list of each operation
   function automatic step_type stepOf(request_type r, logic [2:0] idx);
      step_type s;
      s = '{addr: r.addr, data: r.data, last: 1'b1};
      unique case (r.op)
         OP_PROGRAM, OP_IDENT: begin
            s.last = 1'b0;
            if (idx == 3'd0) begin
               s.addr = UNLOCK1_ADDR;
               s.data = UNLOCK1_DATA;
            end else if (idx == 3'd1) begin
               s.addr = UNLOCK2_ADDR;
               s.data = UNLOCK2_DATA;
            end else if (idx == 3'd2) begin
               s.addr = UNLOCK1_ADDR;
               s.data = (r.op == OP_IDENT) ? CMD_IDENT : CMD_PROGRAM;
               s.last = (r.op == OP_IDENT);
            end else begin
               s.last = 1'b1;
            end
         end
         OP_RESET: s.data = CMD_RESET; // address is don't-care [R18]
         OP_WRITE: s.data = r.data;
         OP_READ, OP_PROTECT, OP_STATUS: s.data = '0;
      endcase
      return s;
   endfunction : stepOf

   function automatic logic isRead(op_type op);
      return op == OP_READ || op == OP_PROTECT || op == OP_STATUS;
   endfunction : isRead

   wire step_type curStep = stepOf(req_r, idx_r);
   wire logic curRead = isRead(req_r.op);
   // protection query puts the sector on the top bits, low address two
   wire logic [18:0] protAddr = {req_r.addr[SECTOR_LSB +: SECTOR_W],
                                 ID_PROT_LOW}; // [R2] [R6]
   wire logic [18:0] rdAddr = (req_r.op == OP_PROTECT) ? protAddr
                                                         : req_r.addr;
   wire logic cntDone = (cnt_r == 4'd0);
   wire logic failHit = (req_r.op == OP_STATUS) && dqSync2_r[FAIL_BIT];
   wire logic take = reqValid && reqReady;

   assign reqReady = clkEn && (state_r == S_IDLE);
   assign rspValid = rspValid_r;
   assign rsp = rsp_r;
   assign identMode = identMode_r;
   assign flashAddr = addr_r;
   assign ceN = ceN_r;
   assign oeN = oeN_r;
   assign weN = weN_r;
   assign dqOut = dqOut_r;
   assign dqOe = dqOe_r;

   // pin data passes two flops; only the second is read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dqSync1_r <= '0;
         dqSync2_r <= '0;
      end else if (clkEn) begin
         dqSync1_r <= dqIn;
         dqSync2_r <= dqSync1_r;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= S_IDLE;
         req_r <= '{op: OP_READ, addr: '0, data: '0};
         idx_r <= '0;
         cnt_r <= '0;
         addr_r <= '0;
         ceN_r <= 1'b1;
         oeN_r <= 1'b1;
         weN_r <= 1'b1;
         dqOe_r <= 1'b0;
         dqOut_r <= '0;
         rspValid_r <= 1'b0;
         rsp_r <= '0;
         identMode_r <= 1'b0;
      end else if (clkEn) begin
         rspValid_r <= 1'b0;
         unique case (state_r)
            S_IDLE: begin
               if (take) begin
                  req_r <= req;
                  idx_r <= '0;
                  rsp_r <= '0;
                  state_r <= S_SETUP;
               end
            end
            S_SETUP: begin
               // address and select settle a cycle before the write strobe; oe falls with them on reads
               ceN_r <= 1'b0;
               addr_r <= curRead ? rdAddr : curStep.addr;
               dqOut_r <= curStep.data;
               dqOe_r <= !curRead;
               if (curRead) begin
                  oeN_r <= 1'b0; // [R23]
                  cnt_r <= 4'(ACCESS + SYNC_CYC - 1);
                  state_r <= S_RLOW;
               end else begin
                  oeN_r <= 1'b1;
                  cnt_r <= 4'(WR_LOW);
                  state_r <= S_WLOW;
               end
            end
            S_WLOW: begin
               if (cntDone) begin
                  weN_r <= 1'b1; // one full pulse per cycle [R25]
                  cnt_r <= 4'(WR_HIGH - 1);
                  state_r <= S_WHIGH;
               end else begin
                  // strobe falls only once address has stood a cycle
                  weN_r <= 1'b0; // [R11]
                  cnt_r <= cnt_r - 4'd1;
               end
            end
            S_WHIGH: begin
               if (cntDone) begin
                  ceN_r <= 1'b1;
                  dqOe_r <= 1'b0;
                  if (curStep.last) begin
                     if (req_r.op == OP_IDENT)
                        identMode_r <= 1'b1; // [R3]
                     else if (req_r.op == OP_RESET)
                        identMode_r <= 1'b0; // [R7]
                     rspValid_r <= 1'b1;
                     state_r <= S_RESP;
                  end else begin
                     idx_r <= idx_r + 3'd1;
                     state_r <= S_SETUP;
                  end
               end else begin
                  cnt_r <= cnt_r - 4'd1;
               end
            end
            S_RLOW: begin
               if (cntDone) begin
                  oeN_r <= 1'b1;
                  ceN_r <= 1'b1;
                  rsp_r.data <= dqSync2_r;
                  if (failHit) begin
                     // failed algorithm: reset before answering [R17]
                     rsp_r.failSeen <= 1'b1;
                     req_r.op <= OP_RESET;
                     idx_r <= '0;
                     state_r <= S_SETUP;
                  end else begin
                     rspValid_r <= 1'b1;
                     state_r <= S_RESP;
                  end
               end else begin
                  cnt_r <= cnt_r - 4'd1;
               end
            end
            S_RESP: state_r <= S_IDLE;
         endcase
      end
   end

   a_write_strobes: assert property ( // [R11]
      @(posedge clk) disable iff (!reset_n)
      !weN_r |-> !ceN_r && oeN_r && dqOe_r)
      else $error("write strobe without ce low and oe high");

   a_read_strobes: assert property ( // [R23]
      @(posedge clk) disable iff (!reset_n)
      !oeN_r |-> !ceN_r && weN_r && !dqOe_r)
      else $error("read strobe with we low or data driven");

   sequence identCmdSeen;
      dqOut_r == CMD_IDENT && addr_r == UNLOCK1_ADDR;
   endsequence

   a_ident_entry: assert property ( // [R3]
      @(posedge clk) disable iff (!reset_n)
      $rose(identMode_r) |-> identCmdSeen)
      else $error("identification mode without its command");

   a_ident_exit: assert property ( // [R7]
      @(posedge clk) disable iff (!reset_n)
      $fell(identMode_r) |-> dqOut_r == CMD_RESET)
      else $error("identification mode left without reset");

   sequence failRead;
      clkEn && state_r == S_RLOW && cntDone && failHit;
   endsequence

   a_fail_reset: assert property ( // [R17]
      @(posedge clk) disable iff (!reset_n)
      failRead |-> ##[1:40] (!weN_r && dqOut_r == CMD_RESET))
      else $error("no reset written after fail flag");

   a_prot_addr: assert property ( // [R6]
      @(posedge clk) disable iff (!reset_n)
      (!oeN_r && req_r.op == OP_PROTECT) |-> addr_r[15:0] == ID_PROT_LOW)
      else $error("protection read at wrong low address");

endmodule : flash_cmd_host

// ==== flash_dev_model.sv ====
// behavioural flash device answering the host controller's strobes
// assumes strobes settle between clk edges; no suspend model, and the
// supply lockout level comes from the bench
`timescale 1ns/1ns
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h3a, // arbitrary value
   parameter logic [7:0] PART_ID = 8'hc6, // arbitrary value
   parameter logic [7:0] PROT = 8'h00
) (
   // strobes and address from host
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic [18:0] flashAddr,
   // supply monitor from the bench
   input wire logic lowSupply,
   // data lanes
   input wire logic [7:0] dqOut,
   output logic [7:0] dqIn
);
   logic [7:0] mem [int];
   logic [18:0] latA;
   logic [7:0] lastQ = 8'h00;
   int step = 0;
   logic ident = 1'b0;
   // strobes held low through power-up never make a command
   logic upHeld = 1'b1;
   initial #1 upHeld = !ceN && !weN && oeN;

   // lockout clears the command state and drops every write
   always @(posedge lowSupply) begin
      step = 0;
      ident = 1'b0;
   end
   wire wrLow = !ceN && !weN;
   wire rdOn = !ceN && !oeN && weN;
   wire [15:0] low = flashAddr[15:0];
   wire [2:0] sect = flashAddr[18:16];
   wire [7:0] idQ = (low == ID_MAKER_LOW) ? MAKER_ID :
      (low == ID_PART_LOW) ? PART_ID :
      (low == ID_PROT_LOW) ? {7'h00, PROT[sect]} : 8'h00;

   // unwritten array bytes read back as their low address byte
   function automatic logic [7:0] arr(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : a[7:0];
   endfunction : arr

   always @(posedge wrLow) latA = flashAddr;

   // one decode per pulse, on the data edge only
   always @(negedge wrLow) begin
      if (upHeld)
         upHeld = 1'b0;
      else if (oeN && !lowSupply) begin
         if (dqOut == CMD_RESET && step != 3) begin
            step = 0;
            ident = 1'b0;
         end else case (step)
            0: step = (latA == UNLOCK1_ADDR && dqOut == UNLOCK1_DATA);
            1: step = (latA == UNLOCK2_ADDR && dqOut == UNLOCK2_DATA) ?
               2 : 0;
            2: begin
               if (latA == UNLOCK1_ADDR && dqOut == CMD_IDENT)
                  ident = 1'b1;
               step = (latA == UNLOCK1_ADDR && dqOut == CMD_PROGRAM) ?
                  3 : 0;
            end
            default: begin
               if (!PROT[latA[18:16]])
                  mem[latA] = arr(latA) & dqOut;
               step = 0;
            end
         endcase
      end
   end

   // released lanes show the inverse, so a stale byte never matches
   always @* begin
      if (rdOn)
         lastQ = ident ? idQ : arr(flashAddr);
      dqIn = rdOn ? lastQ : ~lastQ;
   end
endmodule : flash_dev_model

// ==== flash_cmd_host_tb.sv ====
// self-checking bench for the flash command host
// assumes the host's default strobe timing and one flash model
`timescale 1ns/1ns
module flash_cmd_host_tb
   import flash_host_pkg::*;
;
   logic clk, reset_n, clkEn, reqValid, reqReady, rspValid, identMode;
   logic ceN, oeN, weN, dqOe, lowSupply;
   logic [18:0] flashAddr;
   logic [7:0] dqOut, dqIn;
   request_type req;
   response_type rsp, got;
   int err_count = 0;
   int n_tests = 0;

   flash_cmd_host u_flash_cmd_host (.clk(clk), .reset_n(reset_n),
      .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady),
      .req(req), .rspValid(rspValid), .rsp(rsp), .identMode(identMode),
      .flashAddr(flashAddr), .ceN(ceN), .oeN(oeN), .weN(weN),
      .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
   flash_dev_model #(.PROT(8'h20)) u_flash_dev_model (.ceN(ceN),
      .oeN(oeN), .weN(weN), .flashAddr(flashAddr), .dqOut(dqOut),
      .dqIn(dqIn), .lowSupply(lowSupply));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task results;
      if (err_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // output-enable never meets write-enable or host-driven lanes
   // looked at mid-cycle, where the strobes have settled
   always @(negedge clk) begin
      if (reset_n && !oeN && (!weN || dqOe)) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, weN, 1'b1);
      end
   end

   task automatic xfer(input op_type op, input logic [18:0] a,
         input logic [7:0] d, input int stall);
      int n;
      n = 0;
      req = '{op: op, addr: a, data: d};
      reqValid = 1'b1;
      while (reqReady !== 1'b1 && n < 50) begin
         @(posedge clk);
         #2;
         n++;
      end
      if (n >= 50) begin
         err_count++;
         results();
      end
      @(posedge clk);
      #2;
      reqValid = 1'b0;
      if (stall > 0) begin
         clkEn = 1'b0;
         repeat (stall) @(posedge clk);
         #2;
         chk({6'h00, ceN, reqReady}, 8'h02);
         clkEn = 1'b1;
      end
      n = 0;
      while (rspValid !== 1'b1 && n < 100) begin
         @(posedge clk);
         #2;
         n++;
      end
      if (n >= 100) begin
         err_count++;
         results();
      end
      got = rsp;
      @(posedge clk);
      #2;
   endtask : xfer

   task automatic t_array;
      xfer(OP_READ, 19'h12345, 8'h00, 4);
      chk(got.data, 8'h45);
      chk({6'h00, got.failSeen, identMode}, 8'h00);
   endtask : t_array

   task automatic t_ident;
      xfer(OP_IDENT, 19'h00000, 8'h00, 0);
      chk({7'h00, identMode}, 8'h01);
      xfer(OP_READ, 19'h00000, 8'h00, 0);
      chk(got.data, 8'h3a);
      xfer(OP_READ, 19'h30001, 8'h00, 0);
      chk(got.data, 8'hc6);
      xfer(OP_PROTECT, 19'h5abcd, 8'h00, 0);
      chk(got.data, 8'h01);
      xfer(OP_PROTECT, 19'h70000, 8'h00, 0);
      chk(got.data, 8'h00);
   endtask : t_ident

   task automatic t_reset;
      xfer(OP_RESET, 19'h6abcd, 8'h00, 0);
      chk({7'h00, identMode}, 8'h00);
      xfer(OP_READ, 19'h00001, 8'h00, 0);
      chk(got.data, 8'h01);
   endtask : t_reset

   task automatic t_program;
      xfer(OP_PROGRAM, 19'h1003f, 8'h3c, 0);
      xfer(OP_READ, 19'h1003f, 8'h00, 0);
      chk(got.data, 8'h3c);
      xfer(OP_PROGRAM, 19'h5003f, 8'h00, 0);
      xfer(OP_READ, 19'h5003f, 8'h00, 0);
      chk(got.data, 8'h3f);
   endtask : t_program

   // the maker byte carries the fail bit, so the host's automatic reset write clears it
   task automatic t_status;
      xfer(OP_IDENT, 19'h00000, 8'h00, 0);
      xfer(OP_STATUS, 19'h00000, 8'h00, 0);
      chk({got.data[6:0], got.failSeen}, {7'h3a, 1'b1});
      chk({7'h00, identMode}, 8'h00);
      xfer(OP_STATUS, 19'h00000, 8'h00, 0);
      chk({got.data[6:0], got.failSeen}, {7'h00, 1'b0});
      xfer(OP_RESET, 19'h00000, 8'h00, 0);
   endtask : t_status

   // lockout drops identification mode and ignores writes while it lasts
   task automatic t_lockout;
      xfer(OP_IDENT, 19'h00000, 8'h00, 0);
      lowSupply = 1'b1;
      xfer(OP_READ, 19'h00001, 8'h00, 0);
      chk(got.data, 8'h01);
      xfer(OP_IDENT, 19'h00000, 8'h00, 0);
      lowSupply = 1'b0;
      xfer(OP_READ, 19'h00001, 8'h00, 0);
      chk(got.data, 8'h01);
      xfer(OP_RESET, 19'h00000, 8'h00, 0);
   endtask : t_lockout

   initial begin
      clkEn = 1'b1;
      lowSupply = 1'b0;
      reqValid = 1'b0;
      req = '0;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      #2;
      reset_n = 1'b1;
      t_array();
      t_ident();
      t_reset();
      t_program();
      t_status();
      t_lockout();
      results();
   end
endmodule : flash_cmd_host_tb
